// *** hw/fcl_map.svh ***
// Timing figures and fixed counts of the flash configuration loader
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH
`define FCL_CLK_PERIOD_NS 10
`define FCL_FLASH_ACCESS_NS 70
`define FCL_START_PULSE_NS 2000
`define FCL_DECOMP_CLOCKS 4
`define FCL_ASYNC_STEPS 4
`define FCL_ASYNC_STROBE_FIRST 1
`define FCL_ASYNC_STROBE_LAST 2
`define FCL_BYTE_BITS 8
`endif

// *** hw/fcl_pkg.sv ***
// Types shared by the flash configuration loader
package fcl_pkg;
  typedef enum logic [1:0] {
    FCL_BYTE_WIDE_SYNC_MODE = 2'h0,
    FCL_BYTE_WIDE_DECOMP_MODE = 2'h1,
    FCL_BIT_SERIAL_MODE = 2'h2,
    FCL_BYTE_WIDE_ASYNC_MODE = 2'h3
  } fcl_mode_t;

  typedef enum logic [2:0] {
    FCL_ST_PULSE = 3'h0,
    FCL_ST_SELECT = 3'h1,
    FCL_ST_READ = 3'h2,
    FCL_ST_SEND = 3'h3,
    FCL_ST_DONE = 3'h4
  } fcl_state_t;

  typedef struct packed {
    logic [7:0] config_data;
    logic serial_config_line;
    logic config_shift_clock;
    logic write_strobe_n;
    logic read_strobe_n;
    logic select_high;
    logic select_low_n;
  } fcl_target_t;

  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
  } fcl_flash_ctl_t;
endpackage

// *** hw/fcl_sync3.sv ***
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module fcl_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        out_reg <= s3_reg;
    end
  end

  assign sync_o = out_reg;
endmodule

// *** hw/fcl_loader.sv ***
// Flash configuration loader: flash reader on mclk, target port on the link clock
`timescale 1ns/1ps
`include "fcl_map.svh"
module fcl_loader #(
  parameter fcl_pkg::fcl_mode_t MODE = fcl_pkg::FCL_BYTE_WIDE_SYNC_MODE,
  parameter int FLASH_W = 16,
  parameter int AW = 22,
  parameter int SEL_W = 2,
  parameter int PAGE_WORDS = 262144,
  parameter int IMAGE_WORDS = 200000,
  parameter bit REMOTE = 1'b1
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic [FLASH_W-1:0] flash_data_i,
  output logic [AW-1:0] flash_addr_o,
  output fcl_pkg::fcl_flash_ctl_t flash_ctl_o,
  input wire logic [SEL_W-1:0] image_select_i,
  input wire logic [SEL_W-1:0] board_select_i,
  input wire logic target_error_status_n_i,
  input wire logic load_complete_flag_i,
  output logic config_start_n_o,
  output fcl_pkg::fcl_target_t target_o
);
  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int UNITS = (MODE == fcl_pkg::FCL_BIT_SERIAL_MODE) ? FLASH_W
                         : FLASH_W / `FCL_BYTE_BITS;
  localparam int SHIFT = (MODE == fcl_pkg::FCL_BIT_SERIAL_MODE) ? 1 : `FCL_BYTE_BITS;
  localparam int PER_UNIT = (MODE == fcl_pkg::FCL_BYTE_WIDE_DECOMP_MODE) ? `FCL_DECOMP_CLOCKS
                            : (MODE == fcl_pkg::FCL_BYTE_WIDE_ASYNC_MODE) ? `FCL_ASYNC_STEPS : 1;
  localparam int FLASH_CYC_I = (`FCL_FLASH_ACCESS_NS + `FCL_CLK_PERIOD_NS - 1)
                               / `FCL_CLK_PERIOD_NS;
  localparam int PULSE_CYC_I = (`FCL_START_PULSE_NS + `FCL_CLK_PERIOD_NS - 1)
                               / `FCL_CLK_PERIOD_NS;
  localparam logic [15:0] FLASH_CYC = 16'(FLASH_CYC_I);
  localparam logic [15:0] PULSE_CYC = 16'(PULSE_CYC_I);
  localparam logic [4:0] UNITS_M1 = 5'(UNITS - 1);
  localparam logic [2:0] PER_UNIT_M1 = 3'(PER_UNIT - 1);
  localparam bit SYNC_MODE = (MODE != fcl_pkg::FCL_BYTE_WIDE_ASYNC_MODE);

  function automatic logic [AW-1:0] page_base(input logic [SEL_W-1:0] sel);
    page_base = AW'(sel) * AW'(PAGE_WORDS);
  endfunction

  // ----------------------------------------------------------------
  // Flash side, mclk domain
  // ----------------------------------------------------------------
  fcl_pkg::fcl_state_t st_reg, st_next;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] end_reg;
  logic [15:0] cnt_reg;
  logic [FLASH_W-1:0] word_reg;
  logic req_tgl_reg;
  logic pend_reg;
  logic seen_reg;
  logic ack_prev_reg;
  logic [SEL_W-1:0] sel_s;
  logic status_n_s;
  logic complete_s;
  logic ack_s;
  logic ack_edge;
  logic configuring;
  logic error_hit;
  logic user_restart;
  logic cnt_done;
  logic [AW-1:0] addr_inc;
  logic ack_tgl_reg;

  fcl_sync3 #(.W(SEL_W + 3)) u_sync_m (
    .clk_i(mclk_i),
    .resetn_i(resetn_i),
    .async_i({REMOTE ? image_select_i : board_select_i, target_error_status_n_i,
              load_complete_flag_i, ack_tgl_reg}),
    .sync_o({sel_s, status_n_s, complete_s, ack_s})
  );

  assign ack_edge = ack_s != ack_prev_reg;
  assign configuring = (st_reg == fcl_pkg::FCL_ST_READ) || (st_reg == fcl_pkg::FCL_ST_SEND);
  assign error_hit = configuring && !status_n_s;
  assign user_restart = (st_reg == fcl_pkg::FCL_ST_DONE) && seen_reg && !complete_s;
  assign cnt_done = (st_reg == fcl_pkg::FCL_ST_PULSE) ? (cnt_reg >= PULSE_CYC - 16'h0001)
                    : (cnt_reg >= FLASH_CYC - 16'h0001);
  assign addr_inc = addr_reg + AW'(1);

  always_comb
  begin
    st_next = st_reg;
    if (error_hit || user_restart)
      st_next = fcl_pkg::FCL_ST_PULSE;
    else
    begin
      unique case (st_reg)
        fcl_pkg::FCL_ST_PULSE: if (cnt_done && !pend_reg) st_next = fcl_pkg::FCL_ST_SELECT;
        fcl_pkg::FCL_ST_SELECT: st_next = fcl_pkg::FCL_ST_READ;
        fcl_pkg::FCL_ST_READ: if (cnt_done) st_next = fcl_pkg::FCL_ST_SEND;
        fcl_pkg::FCL_ST_SEND: if (ack_edge)
          st_next = (addr_inc == end_reg) ? fcl_pkg::FCL_ST_DONE : fcl_pkg::FCL_ST_READ;
        fcl_pkg::FCL_ST_DONE: st_next = fcl_pkg::FCL_ST_DONE;
        default: st_next = fcl_pkg::FCL_ST_PULSE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_reg <= fcl_pkg::FCL_ST_PULSE;
      addr_reg <= '0;
      end_reg <= '0;
      cnt_reg <= 16'h0000;
      word_reg <= '0;
      req_tgl_reg <= 1'b0;
      pend_reg <= 1'b0;
      seen_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      ack_prev_reg <= ack_s;
      cnt_reg <= (st_next != st_reg) ? 16'h0000 : cnt_reg + 16'h0001;
      seen_reg <= (st_reg == fcl_pkg::FCL_ST_DONE) && (seen_reg || complete_s);
      if (st_reg == fcl_pkg::FCL_ST_SELECT)
      begin
        addr_reg <= page_base(sel_s);
        end_reg <= page_base(sel_s) + AW'(IMAGE_WORDS);
      end
      if (st_reg == fcl_pkg::FCL_ST_READ && cnt_done && !error_hit)
      begin
        word_reg <= flash_data_i;
        req_tgl_reg <= !req_tgl_reg;
      end
      // Set beats clear: a new request never coincides with an ack in flight
      if (st_reg == fcl_pkg::FCL_ST_READ && cnt_done && !error_hit)
        pend_reg <= 1'b1;
      else if (ack_edge)
        pend_reg <= 1'b0;
      if (st_reg == fcl_pkg::FCL_ST_SEND && ack_edge)
        addr_reg <= addr_inc;
    end
  end

  assign flash_addr_o = addr_reg;
  assign flash_ctl_o.chip_enable_n = !configuring;
  assign flash_ctl_o.output_enable_n = st_reg != fcl_pkg::FCL_ST_READ;
  assign config_start_n_o = st_reg != fcl_pkg::FCL_ST_PULSE;

  // ----------------------------------------------------------------
  // Target side, link clock domain
  // ----------------------------------------------------------------
  logic req_s;
  logic req_prev_reg;
  logic busy_reg;
  logic hi_reg;
  logic [2:0] sub_reg;
  logic [4:0] left_reg;
  logic [FLASH_W-1:0] shift_reg;
  logic unit_end;
  logic step;

  fcl_sync3 #(.W(1)) u_sync_l (
    .clk_i(link_clk_i),
    .resetn_i(resetn_i),
    .async_i(req_tgl_reg),
    .sync_o(req_s)
  );

  // Sync modes step on the falling shift edge so data is stable for the rise
  assign step = busy_reg && (SYNC_MODE ? hi_reg : 1'b1);
  assign unit_end = step && (sub_reg == PER_UNIT_M1);

  always_ff @(posedge link_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      req_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      hi_reg <= 1'b0;
      sub_reg <= 3'h0;
      left_reg <= 5'h00;
      shift_reg <= '0;
      ack_tgl_reg <= 1'b0;
    end
    else
    begin
      req_prev_reg <= req_s;
      hi_reg <= busy_reg && SYNC_MODE && !hi_reg;
      if (!busy_reg && req_s != req_prev_reg)
      begin
        // Word is held steady on the mclk side until the ack returns
        shift_reg <= word_reg;
        busy_reg <= 1'b1;
        left_reg <= UNITS_M1;
        sub_reg <= 3'h0;
      end
      else if (unit_end)
      begin
        sub_reg <= 3'h0;
        if (left_reg == 5'h00)
        begin
          busy_reg <= 1'b0;
          ack_tgl_reg <= !ack_tgl_reg;
        end
        else
        begin
          left_reg <= left_reg - 5'h01;
          shift_reg <= shift_reg >> SHIFT;
        end
      end
      else if (step)
        sub_reg <= sub_reg + 3'h1;
    end
  end

  assign target_o.config_data = shift_reg[7:0];
  assign target_o.serial_config_line = shift_reg[0];
  assign target_o.config_shift_clock = hi_reg;
  assign target_o.write_strobe_n = !(busy_reg && !SYNC_MODE
                                     && sub_reg >= 3'(`FCL_ASYNC_STROBE_FIRST)
                                     && sub_reg <= 3'(`FCL_ASYNC_STROBE_LAST));
  assign target_o.read_strobe_n = 1'b1;
  assign target_o.select_high = busy_reg && !SYNC_MODE;
  assign target_o.select_low_n = !(busy_reg && !SYNC_MODE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_error_seen;
    configuring && !status_n_s;
  endsequence

  error_restart_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_error_seen |=> st_reg == fcl_pkg::FCL_ST_PULSE && !config_start_n_o)
    else $error("error status did not restart configuration");
  done_restart_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (st_reg == fcl_pkg::FCL_ST_DONE && seen_reg && !complete_s) |=> !config_start_n_o)
    else $error("completion drop did not restart");
  page_base_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    st_reg == fcl_pkg::FCL_ST_SELECT |=> addr_reg == page_base($past(sel_s)))
    else $error("start address not from page select");
  select_first_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (st_reg == fcl_pkg::FCL_ST_PULSE && st_next == fcl_pkg::FCL_ST_SELECT)
    |=> ##1 st_reg != fcl_pkg::FCL_ST_SELECT)
    else $error("page select state held too long");
  fetch_after_ack_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (st_reg == fcl_pkg::FCL_ST_SEND && ack_edge && !error_hit) |=> addr_reg == $past(addr_inc))
    else $error("flash address not advanced after word sent");
  pulse_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $fell(config_start_n_o) |-> !config_start_n_o [*8])
    else $error("start pulse too short");
  clock_toggle_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    (SYNC_MODE && busy_reg && !hi_reg && !unit_end) |=> hi_reg)
    else $error("shift clock stalled mid word");
  data_on_fall_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    (busy_reg && SYNC_MODE && !hi_reg) |=> $stable(target_o.config_data))
    else $error("data moved on rising shift edge");
  unit_count_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    (busy_reg && step && sub_reg != PER_UNIT_M1) |=> $stable(shift_reg))
    else $error("data advanced before unit clocks elapsed");
  async_no_clock_a: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
    !SYNC_MODE |-> !target_o.config_shift_clock)
    else $error("shift clock active in async mode");
endmodule

// *** testbench/fcl_partner.sv ***
// Behavioural flash memory and target configuration port facing the loader
`timescale 1ns/1ps
module fcl_partner #(
  parameter fcl_pkg::fcl_mode_t MODE = fcl_pkg::FCL_BYTE_WIDE_SYNC_MODE,
  parameter int AW = 22
) (
  input wire logic config_start_n_i,
  input wire logic [AW-1:0] flash_addr_i,
  input wire fcl_pkg::fcl_flash_ctl_t flash_ctl_i,
  input wire fcl_pkg::fcl_target_t target_i,
  output logic [15:0] flash_data_o,
  output logic [7:0] cap_o [0:31],
  output int cap_cnt_o,
  output int rise_cnt_o,
  output logic [AW-1:0] first_addr_o
);
  // ----------------------------------------
  // Flash
  // ----------------------------------------
  logic [15:0] last = 16'h0000;
  logic seen = 1'b0;
  logic [7:0] sh = 8'h00;
  int bits = 0;
  wire rd = !flash_ctl_i.chip_enable_n && !flash_ctl_i.output_enable_n;
  // Released bus shows the inverse of the last word, so stale data never matches
  assign flash_data_o = rd ? {~flash_addr_i[7:0], flash_addr_i[7:0] ^ 8'h5A} : ~last;
  always @(flash_data_o) if (rd) last = flash_data_o;
  // Address and enable move on the same edge, so look once both have settled
  always @(negedge flash_ctl_i.output_enable_n)
  begin
    #1;
    if (!seen) first_addr_o = flash_addr_i;
    seen = 1'b1;
  end
  // ----------------------------------------
  // Target port
  // ----------------------------------------
  task automatic store(input logic [7:0] b);
    if (cap_cnt_o < 32) cap_o[cap_cnt_o] = b;
    cap_cnt_o++;
  endtask
  // Start pulse resets the target, as a real one would
  always @(negedge config_start_n_i)
  begin
    cap_cnt_o = 0;
    rise_cnt_o = 0;
    seen = 1'b0;
    bits = 0;
  end
  // A word still in flight during the start pulse is lost, as the target is held in reset
  always @(posedge target_i.config_shift_clock)
  begin
    if (config_start_n_i === 1'b1)
    begin
      if (MODE == fcl_pkg::FCL_BIT_SERIAL_MODE)
      begin
        sh = {target_i.serial_config_line, sh[7:1]};
        bits++;
        if (bits % 8 == 0) store(sh);
      end
      else if (MODE == fcl_pkg::FCL_BYTE_WIDE_SYNC_MODE || rise_cnt_o % 4 == 0)
        store(target_i.config_data);
      rise_cnt_o++;
    end
  end
  always @(posedge target_i.write_strobe_n)
    if (MODE == fcl_pkg::FCL_BYTE_WIDE_ASYNC_MODE && config_start_n_i === 1'b1 &&
        target_i.read_strobe_n === 1'b1 && target_i.select_high &&
        !target_i.select_low_n) store(target_i.config_data);
endmodule

// *** testbench/fcl_loader_tb_top.sv ***
// Self-checking bench running all four loader modes side by side
`timescale 1ns/1ps
module fcl_loader_tb_top;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int PW = 16;
  localparam int IW = 4;
  localparam int NB = 2 * IW;
  localparam int RISES [4] = '{NB, 4 * NB, 8 * NB, 0};
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic err_n = 1'b1;
  logic flag = 1'b0;
  logic [1:0] sel = 2'h1;
  int err_total = 0;
  int tests_run = 0;
  logic start_n [4];
  logic [7:0] cap [4][0:31];
  int ccnt [4];
  int rcnt [4];
  logic [21:0] first [4];
  initial forever #5 mclk = ~mclk;
  initial
  begin
    #3;
    forever #32 link_clk = ~link_clk;
  end
  for (genvar i = 0; i < 4; i++)
  begin : g_mode
    logic [21:0] addr;
    fcl_pkg::fcl_flash_ctl_t ctl;
    fcl_pkg::fcl_target_t tgt;
    logic [15:0] fdata;
    // The async instance takes its page from the board switches; the other pins lie
    fcl_loader #(.MODE(fcl_pkg::fcl_mode_t'(i)), .PAGE_WORDS(PW), .IMAGE_WORDS(IW),
                 .REMOTE(i != 3)) u_fcl_loader (
      .mclk_i(mclk), .resetn_i(resetn), .link_clk_i(link_clk), .flash_data_i(fdata),
      .flash_addr_o(addr), .flash_ctl_o(ctl),
      .image_select_i((i == 3) ? ~sel : sel), .board_select_i((i == 3) ? sel : ~sel),
      .target_error_status_n_i(err_n), .load_complete_flag_i(flag),
      .config_start_n_o(start_n[i]), .target_o(tgt));
    fcl_partner #(.MODE(fcl_pkg::fcl_mode_t'(i)), .AW(22)) u_fcl_partner (
      .config_start_n_i(start_n[i]), .flash_addr_i(addr), .flash_ctl_i(ctl),
      .target_i(tgt), .flash_data_o(fdata), .cap_o(cap[i]), .cap_cnt_o(ccnt[i]),
      .rise_cnt_o(rcnt[i]), .first_addr_o(first[i]));
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic watch(output logic [3:0] fell);
    fell = 4'h0;
    repeat (1000)
    begin
      @(posedge mclk);
      for (int i = 0; i < 4; i++) if (start_n[i] === 1'b0) fell[i] = 1'b1;
    end
  endtask
  // Whole image per mode: address, bytes, order and clock count
  task automatic t_pass(input logic [21:0] base);
    int n;
    logic [7:0] a;
    logic [7:0] e;
    n = 0;
    while (n < 40000 && !(ccnt[0] >= NB && ccnt[1] >= NB && ccnt[2] >= NB && ccnt[3] >= NB))
    begin
      @(posedge mclk);
      n++;
    end
    repeat (300) @(posedge mclk);
    for (int i = 0; i < 4; i++)
    begin
      check("first_addr", first[i], base);
      check("byte_count", ccnt[i], NB);
      check("shift_rises", rcnt[i], RISES[i]);
      check("start_idle", start_n[i], 1'b1);
      for (int k = 0; k < NB; k++)
      begin
        a = 8'(base + k / 2);
        e = (k % 2) ? ~a : a ^ 8'h5A;
        check("config_byte", cap[i][k], e);
      end
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reload;
    logic [3:0] fell;
    @(posedge mclk);
    #1 sel = 2'h2;
    repeat (50) @(posedge mclk);
    #1 flag = 1'b1;
    repeat (20) @(posedge mclk);
    #1 flag = 1'b0;
    watch(fell);
    check("restart_on_done", fell, 4'hF);
    t_pass(22'h20);
  endtask
  // Error strobe in mid-image, while every mode is still sending
  task automatic t_error;
    int n;
    logic [3:0] fell;
    // Every mode is idle after the last pass, so start a fresh one first
    #1 flag = 1'b1;
    repeat (20) @(posedge mclk);
    #1 flag = 1'b0;
    n = 0;
    while (n < 100 && start_n[0] !== 1'b0)
    begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (n < 20000 && ccnt[0] < 3)
    begin
      @(posedge mclk);
      n++;
    end
    #1 err_n = 1'b0;
    repeat (20) @(posedge mclk);
    #1 err_n = 1'b1;
    watch(fell);
    check("restart_on_error", fell, 4'hF);
    t_pass(22'h20);
  endtask
  initial
  begin
    #400000;
    err_total++;
    test_done();
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 resetn = 1'b1;
    t_pass(22'h10);
    t_reload();
    t_error();
    test_done();
  end
endmodule
